// file: common/fifo_flags_consts.svh
`ifndef FIFO_FLAGS_CONSTS_SVH
`define FIFO_FLAGS_CONSTS_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define FF_DEPTH_DEFAULT 8192
`define FF_DATA_W        18
`define FF_NARROW_W      9

// ----------------------------------------
// register stages
// ----------------------------------------
`define FF_PTR_SYNC_STAGES 2

// ----------------------------------------
// reset values (full, empty, outvalid internal active-high; almost-full, almost-empty, half-full active-low pins)
// ----------------------------------------
`define FF_FULL_RST        1'b0
`define FF_EMPTY_RST       1'b1
`define FF_OUTVALID_RST    1'b0
`define FF_ALMOST_FULL_RST 1'b1
`define FF_ALMOST_EMPTY_RST 1'b0
`define FF_HALF_FULL_RST   1'b1

`endif

// file: common/fifo_flags_pkg.sv
package fifo_flags_pkg;

	// ----------------------------------------
	// programmable flag timing, one-hot
	// ----------------------------------------
	typedef enum logic [1:0] {
		TIMING_ASYNC = 2'h1,
		TIMING_SYNC  = 2'h2
	} flag_timing_t;

endpackage

// file: rtl/fifo_status_flags.sv
// Function
// [RULE1] fall-through: shared full pin is active-low input ready, high blocks writes
// [RULE2] fall-through: input ready goes high after depth plus one writes
// [RULE3] standard: shared pin is active-low full flag, low blocks writes
// [RULE4] standard: full flag goes low after depth writes, depth doubles for x9
// [RULE5] input-ready count includes the word held in the output register
// [RULE6] full pin changes on write clock edges only, two register stages
// [RULE7] fall-through: output ready falls together with first valid data
// [RULE8] output ready rises only on a true read; last data held
// [RULE9] standard: shared pin is active-low empty flag, low blocks reads
// [RULE10] empty pin changes on read edges; three stages fall-through, two standard
// [RULE11] fall-through: almost-full low after depth plus one minus m writes
// [RULE12] standard: almost-full low after depth minus m writes
// [RULE13] almost-full: async set by write, cleared by read; sync write-only
// [RULE14] almost-empty low at occupancy up to n, plus one in fall-through
// [RULE15] almost-empty: async set by read, cleared by write; sync read-only
// [RULE16] half-full set low by write edge, set high by read edge
// [RULE17] fall-through: half-full low after ((D-1)/2)+2 writes
// [RULE18] standard: half-full low after half depth plus one writes
// [RULE19] data output carries 18 bits wide or 9 bits narrow
// [RULE20] thresholds counted in units of the wider bus width
// [RULE21] flag timing select latched during master reset; low async, high sync
// [RULE22] flags hold while their clock is stopped
// [RULE23] pointers cross between write and read sides through synchronizers
// [RULE24] writer stops on full, reader stops on empty or not ready
`timescale 1ns/1ps
`include "fifo_flags_consts.svh"

module fifo_status_flags import fifo_flags_pkg::*; #(
	parameter int DEPTH  = `FF_DEPTH_DEFAULT,
	parameter int DATA_W = `FF_DATA_W,
	parameter int CW     = $clog2(DEPTH) + 2,
	parameter int AW     = $clog2(DEPTH) + 1
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              master_reset_n,
	input  wire logic              partial_reset_n,
	input  wire logic              fall_through_mode,
	input  wire logic              flag_timing_select,
	input  wire logic              inNarrow,
	input  wire logic              outNarrow,
	input  wire logic              writeClk,
	input  wire logic              writeEnableN,
	input  wire logic              readClk,
	input  wire logic              readEnableN,
	input  wire logic [CW-1:0]     fullOffset,
	input  wire logic [CW-1:0]     emptyOffset,
	input  wire logic [DATA_W-1:0] arrayData,
	output logic      [AW-1:0]     arrayWriteAddr,
	output logic                   arrayWriteStrobe,
	output logic      [AW-1:0]     arrayReadAddr,
	output logic                   full_flag_n,
	output logic                   empty_flag_n,
	output logic                   almost_full_n,
	output logic                   almost_empty_n,
	output logic                   half_full_n,
	output logic      [DATA_W-1:0] data_out
);

	// ----------------------------------------
	// configuration caught during master reset
	// ----------------------------------------
	logic         fwftMode;
	flag_timing_t timing;
	logic         bothNarrow;
	logic         outNarrowCfg;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fwftMode     <= 1'b0;
			timing       <= TIMING_ASYNC;
			bothNarrow   <= 1'b0;
			outNarrowCfg <= 1'b0;
		end else if (!master_reset_n) begin
			fwftMode     <= fall_through_mode;
			timing       <= flag_timing_select ? TIMING_SYNC : TIMING_ASYNC; // RULE21
			bothNarrow   <= inNarrow & outNarrow;
			outNarrowCfg <= outNarrow;
		end
	end

	// ----------------------------------------
	// clock pin edges, sampled on clk
	// ----------------------------------------
	logic writeClkPrev;
	logic readClkPrev;
	wire  wEdge = writeClk & ~writeClkPrev;
	wire  rEdge = readClk & ~readClkPrev;
	wire  anyReset = ~master_reset_n | ~partial_reset_n;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			writeClkPrev <= 1'b0;
			readClkPrev  <= 1'b0;
		end else begin
			writeClkPrev <= writeClk;
			readClkPrev  <= readClk;
		end
	end

	// ----------------------------------------
	// thresholds, in units of the wider bus
	// ----------------------------------------
	wire [CW-1:0] fwftExtra = {{(CW-1){1'b0}}, fwftMode};
	wire [CW-1:0] depthEff  = bothNarrow ? CW'(2 * DEPTH) : CW'(DEPTH); // RULE20
	wire [CW-1:0] fullLimit = depthEff + fwftExtra; // RULE2 RULE4 RULE5
	wire [CW-1:0] pafLimit  = fullLimit - fullOffset; // RULE11 RULE12
	wire [CW-1:0] paeLimit  = emptyOffset + fwftExtra; // RULE14
	wire [CW-1:0] hfLimit   = (depthEff >> 1) + fwftExtra; // RULE17 RULE18

	// ----------------------------------------
	// pointers and crossings
	// ----------------------------------------
	logic [CW-1:0] wrPtr;
	logic [CW-1:0] takePtr;
	logic [CW-1:0] readCount;
	logic [CW-1:0] wrPtrR;
	logic [CW-1:0] readCountW;

	ptr_sync #(.WIDTH(CW), .STAGES(`FF_PTR_SYNC_STAGES)) u_wr2rd ( // RULE23
		.clk     (clk),
		.sys_rst (sys_rst),
		.din     (wrPtr),
		.dout    (wrPtrR)
	);

	ptr_sync #(.WIDTH(CW), .STAGES(`FF_PTR_SYNC_STAGES)) u_rd2wr ( // RULE23
		.clk     (clk),
		.sys_rst (sys_rst),
		.din     (readCount),
		.dout    (readCountW)
	);

	// ----------------------------------------
	// write side
	// ----------------------------------------
	logic fullS1;
	logic fullS2;

	wire [CW-1:0] occW        = wrPtr - readCountW;
	wire          fullNow     = occW >= fullLimit;
	// writes refused while full, whatever the pin shows
	wire          writeAccept = wEdge & ~writeEnableN & ~fullNow; // RULE1 RULE3
	wire [CW-1:0] occWNext    = occW + {{(CW-1){1'b0}}, writeAccept};
	wire          next_full   = occWNext >= fullLimit; // RULE2 RULE4

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr  <= '0;
			fullS1 <= `FF_FULL_RST;
			fullS2 <= `FF_FULL_RST;
		end else if (anyReset) begin
			wrPtr  <= '0;
			fullS1 <= `FF_FULL_RST;
			fullS2 <= `FF_FULL_RST;
		end else if (wEdge) begin // RULE6 RULE22
			wrPtr  <= occWNext + readCountW;
			fullS1 <= next_full;
			fullS2 <= fullS1;
		end
	end

	assign arrayWriteAddr   = wrPtr[AW-1:0];
	assign arrayWriteStrobe = writeAccept & master_reset_n & partial_reset_n;
	// same pin, inverted sense between modes
	assign full_flag_n      = fwftMode ? fullS2 : ~fullS2; // RULE1 RULE3

	// ----------------------------------------
	// read side
	// ----------------------------------------
	logic outValid;
	logic availS1;
	logic availS2;
	logic emptyS1;
	logic emptyS2;

	wire [CW-1:0] arrayCount = wrPtrR - takePtr;
	wire          arrayHas   = arrayCount != '0;
	// reads refused on empty array or idle output register
	wire          stdRead    = rEdge & ~readEnableN & arrayHas & ~fwftMode; // RULE9
	wire          trueRead   = rEdge & ~readEnableN & outValid & fwftMode; // RULE8
	// availability seen through two read stages before the load
	wire          loadOut    = fwftMode & rEdge & arrayHas & availS2 &
		(~outValid | trueRead); // RULE7 RULE10
	wire          take       = stdRead | loadOut;
	wire          consume    = stdRead | trueRead;
	wire [CW-1:0] next_take  = takePtr + {{(CW-1){1'b0}}, take};
	wire [CW-1:0] next_count = readCount + {{(CW-1){1'b0}}, consume};
	wire          next_empty = (wrPtrR - next_take) == '0;
	wire          next_outValid = loadOut | (outValid & ~trueRead); // RULE8

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			takePtr   <= '0;
			readCount <= '0;
			outValid  <= `FF_OUTVALID_RST;
			availS1   <= 1'b0;
			availS2   <= 1'b0;
			emptyS1   <= `FF_EMPTY_RST;
			emptyS2   <= `FF_EMPTY_RST;
		end else if (anyReset) begin
			takePtr   <= '0;
			readCount <= '0;
			outValid  <= `FF_OUTVALID_RST;
			availS1   <= 1'b0;
			availS2   <= 1'b0;
			emptyS1   <= `FF_EMPTY_RST;
			emptyS2   <= `FF_EMPTY_RST;
		end else if (rEdge) begin // RULE10 RULE22
			takePtr   <= next_take;
			readCount <= next_count;
			outValid  <= next_outValid;
			availS1   <= arrayHas;
			availS2   <= availS1;
			emptyS1   <= next_empty;
			emptyS2   <= emptyS1;
		end
	end

	// data register: last word held when nothing is taken
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_out <= '0;
		end else if (anyReset) begin
			// cleared so a width change never leaves stale upper bits
			data_out <= '0;
		end else if (take) begin
			data_out <= outNarrowCfg ?
				{{(DATA_W-`FF_NARROW_W){1'b0}}, arrayData[`FF_NARROW_W-1:0]} :
				arrayData; // RULE19
		end
	end

	assign arrayReadAddr = takePtr[AW-1:0];
	assign empty_flag_n  = fwftMode ? ~outValid : ~emptyS2; // RULE7 RULE9

	// ----------------------------------------
	// programmable and half-full flags
	// ----------------------------------------
	wire [CW-1:0] occR     = wrPtrR - readCount;
	wire [CW-1:0] occRNext = wrPtrR - next_count;
	wire          isSync   = timing == TIMING_SYNC;

	wire pafSetW   = wEdge & (occWNext >= pafLimit);
	wire pafClearR = rEdge & (occRNext < pafLimit);
	wire paeSetR   = rEdge & (occRNext <= paeLimit);
	wire paeClearW = wEdge & (occWNext > paeLimit);
	wire hfSetW    = wEdge & (occWNext > hfLimit);
	wire hfClearR  = rEdge & (occRNext <= hfLimit);

	logic next_almostFull;
	logic next_almostEmpty;
	logic next_halfFull;

	always_comb begin
		next_almostFull  = almost_full_n;
		next_almostEmpty = almost_empty_n;
		unique case (timing)
			TIMING_SYNC: begin
				if (wEdge) begin
					next_almostFull = ~pafSetW; // RULE13
				end
				if (rEdge) begin
					next_almostEmpty = ~paeSetR; // RULE15
				end
			end
			TIMING_ASYNC: begin
				// an assert beats a release in one cycle: write for almost-full, read for almost-empty
				if (pafSetW) begin
					next_almostFull = 1'b0; // RULE13
				end else if (pafClearR) begin
					next_almostFull = 1'b1;
				end
				if (paeSetR) begin
					next_almostEmpty = 1'b0; // RULE15
				end else if (paeClearW) begin
					next_almostEmpty = 1'b1;
				end
			end
			default: begin
				next_almostFull  = almost_full_n;
				next_almostEmpty = almost_empty_n;
			end
		endcase
	end

	assign next_halfFull = hfSetW ? 1'b0 : (hfClearR ? 1'b1 : half_full_n); // RULE16

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			almost_full_n  <= `FF_ALMOST_FULL_RST;
			almost_empty_n <= `FF_ALMOST_EMPTY_RST;
			half_full_n    <= `FF_HALF_FULL_RST;
		end else if (anyReset) begin
			almost_full_n  <= `FF_ALMOST_FULL_RST;
			almost_empty_n <= `FF_ALMOST_EMPTY_RST;
			half_full_n    <= `FF_HALF_FULL_RST;
		end else begin
			almost_full_n  <= next_almostFull;
			almost_empty_n <= next_almostEmpty;
			half_full_n    <= next_halfFull;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	wire quiet = master_reset_n & partial_reset_n;

	property p_full_block;
		@(posedge clk) disable iff (sys_rst)
		writeAccept |-> occW < fullLimit;
	endproperty
	a_full_block: assert property (p_full_block) // RULE1
		else $error("write accepted while full");

	property p_full_bound;
		@(posedge clk) disable iff (sys_rst)
		quiet |-> occW <= fullLimit;
	endproperty
	a_full_bound: assert property (p_full_bound) // RULE5
		else $error("occupancy beyond limit");

	property p_full_edge;
		@(posedge clk) disable iff (sys_rst)
		(!$stable(full_flag_n) && $past(quiet) && $stable(fwftMode))
			|-> $past(wEdge);
	endproperty
	a_full_edge: assert property (p_full_edge) // RULE6
		else $error("full pin moved without write edge");

	property p_empty_edge;
		@(posedge clk) disable iff (sys_rst)
		(!$stable(empty_flag_n) && $past(quiet) && $stable(fwftMode))
			|-> $past(rEdge);
	endproperty
	a_empty_edge: assert property (p_empty_edge) // RULE10
		else $error("empty pin moved without read edge");

	property p_ready_with_data;
		@(posedge clk) disable iff (sys_rst)
		(fwftMode && $fell(empty_flag_n)) |-> $past(loadOut) && !$stable(data_out)
			|| $past(arrayData) == data_out;
	endproperty
	a_ready_with_data: assert property (p_ready_with_data) // RULE7
		else $error("output ready fell without data load");

	property p_ready_rise;
		@(posedge clk) disable iff (sys_rst)
		(fwftMode && $rose(empty_flag_n) && $past(quiet))
			|-> $past(rEdge && !readEnableN);
	endproperty
	a_ready_rise: assert property (p_ready_rise) // RULE8
		else $error("output ready rose without true read");

	property p_narrow_out;
		@(posedge clk) disable iff (sys_rst)
		outNarrowCfg && $past(outNarrowCfg)
			|-> data_out[DATA_W-1:`FF_NARROW_W] == '0;
	endproperty
	a_narrow_out: assert property (p_narrow_out) // RULE19
		else $error("narrow output upper bits set");

	property p_paf_sync;
		@(posedge clk) disable iff (sys_rst)
		(isSync && !$stable(almost_full_n) && $past(quiet)) |-> $past(wEdge);
	endproperty
	a_paf_sync: assert property (p_paf_sync) // RULE13
		else $error("sync almost-full moved without write edge");

	property p_pae_sync;
		@(posedge clk) disable iff (sys_rst)
		(isSync && !$stable(almost_empty_n) && $past(quiet)) |-> $past(rEdge);
	endproperty
	a_pae_sync: assert property (p_pae_sync) // RULE15
		else $error("sync almost-empty moved without read edge");

	property p_half_dirs;
		@(posedge clk) disable iff (sys_rst)
		$fell(half_full_n) |-> $past(wEdge) ##0 $past(occWNext) > $past(hfLimit);
	endproperty
	a_half_dirs: assert property (p_half_dirs) // RULE16
		else $error("half-full fell without write edge past half");

	property p_timing_latch;
		@(posedge clk) disable iff (sys_rst)
		!master_reset_n |=> isSync == $past(flag_timing_select);
	endproperty
	a_timing_latch: assert property (p_timing_latch) // RULE21
		else $error("flag timing not latched at master reset");

endmodule

// file: rtl/ptr_sync.sv
`timescale 1ns/1ps

module ptr_sync #(
	parameter int WIDTH  = 16,
	parameter int STAGES = 2
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage [STAGES];

	// first stage feeds only the next stage
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < STAGES; i++) begin
				stage[i] <= '0;
			end
		end else begin
			stage[0] <= din;
			for (int i = 1; i < STAGES; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	assign dout = stage[STAGES-1];

endmodule

// file: testbench/dual_clock_fifo_status_flags_tb.sv
`timescale 1ns/1ps

module dual_clock_fifo_status_flags_tb;
	localparam int D0  = 16;
	localparam int CWT = $clog2(D0) + 2;
	localparam int AWT = $clog2(D0) + 1;

	logic           clk, sys_rst, master_reset_n;
	logic           partialResetN;
	logic           fall_through_mode, flag_timing_select;
	logic           inNarrow, outNarrow;
	logic           writeClk, writeEnableN, readClk, readEnableN;
	logic [CWT-1:0] fullOffset, emptyOffset;
	logic [AWT-1:0] arrayWriteAddr, arrayReadAddr;
	logic           arrayWriteStrobe;
	logic           full_flag_n, empty_flag_n;
	logic           almost_full_n, almost_empty_n, half_full_n;
	logic [17:0]    arrayData, data_out, lastOut;
	logic [7:0]     cnt;
	int             numErrors, checksDone, occ;
	logic [17:0]    expQ [$];

	fifo_status_flags #(.DEPTH(D0)) fifo_status_flags_inst (
		.clk(clk), .sys_rst(sys_rst), .master_reset_n(master_reset_n),
		.partial_reset_n(partialResetN),
		.fall_through_mode(fall_through_mode),
		.flag_timing_select(flag_timing_select), .inNarrow(inNarrow),
		.outNarrow(outNarrow), .writeClk(writeClk),
		.writeEnableN(writeEnableN), .readClk(readClk),
		.readEnableN(readEnableN), .fullOffset(fullOffset),
		.emptyOffset(emptyOffset), .arrayData(arrayData),
		.arrayWriteAddr(arrayWriteAddr),
		.arrayWriteStrobe(arrayWriteStrobe),
		.arrayReadAddr(arrayReadAddr), .full_flag_n(full_flag_n),
		.empty_flag_n(empty_flag_n), .almost_full_n(almost_full_n),
		.almost_empty_n(almost_empty_n), .half_full_n(half_full_n),
		.data_out(data_out));

	fifo_peer_model #(.AW(AWT)) fifo_peer_model_inst (
		.clk(clk), .fall_through_mode(fall_through_mode),
		.full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
		.arrayWriteAddr(arrayWriteAddr),
		.arrayWriteStrobe(arrayWriteStrobe),
		.arrayReadAddr(arrayReadAddr), .writeClk(writeClk),
		.writeEnableN(writeEnableN), .readClk(readClk),
		.readEnableN(readEnableN), .arrayData(arrayData));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------
	// comparison and verdict
	// ----------------------------------------
	task automatic check(input string what, input logic [17:0] seen,
			input logic [17:0] exp);
		checksDone++;
		if (seen !== exp) begin
			numErrors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic flag(input string what, input logic seen, input logic exp);
		check(what, 18'(seen), 18'(exp));
	endtask

	task automatic finish_test();
		if (numErrors == 0 && checksDone > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// a result is any change of the output word; refused reads show none
	always @(posedge clk) begin
		if (!sys_rst && master_reset_n && partialResetN &&
				data_out !== lastOut) begin
			if (expQ.size() == 0) begin
				check("data_out held", data_out, lastOut);
			end else begin
				check("data_out", data_out, expQ.pop_front());
			end
		end
		lastOut <= data_out;
	end

	// ----------------------------------------
	// flag expectations from occupancy
	// ----------------------------------------
	task automatic check_flags();
		int   dep, lim, m, n;
		logic ft;
		ft  = fall_through_mode;
		dep = (inNarrow && outNarrow) ? 2 * D0 : D0;
		lim = ft ? dep + 1 : dep;
		m   = int'(fullOffset);
		n   = int'(emptyOffset);
		flag("full", full_flag_n, ft ? occ >= lim : occ < lim);
		flag("empty", empty_flag_n, ft ? occ == 0 : occ != 0);
		flag("afull", almost_full_n, !(occ >= lim - m));
		flag("aempty", almost_empty_n, !(occ <= n + int'(ft)));
		flag("half", half_full_n, !(occ > dep / 2 + int'(ft)));
	endtask

	// op: 0 write, 1 read, 2 write past flags, 3 read past flags
	task automatic step(input int op);
		int          lim;
		logic [17:0] d;
		lim = (inNarrow && outNarrow) ? 2 * D0 : D0;
		lim = fall_through_mode ? lim + 1 : lim;
		d   = {10'($urandom()), cnt};
		cnt++;
		if (op == 0 || op == 2) begin
			if (occ < lim) begin
				expQ.push_back(outNarrow ? (d & 18'h001FF) : d);
				occ++;
			end
			fifo_peer_model_inst.pulse_write(1'b1, op == 0, d);
		end else begin
			if (occ > 0) begin
				occ--;
			end
			fifo_peer_model_inst.pulse_read(1'b1, op == 1);
		end
		// idle edges on both sides let every flag settle
		repeat (4) fifo_peer_model_inst.pulse_write(1'b0, 1'b1, ~d);
		repeat (4) fifo_peer_model_inst.pulse_read(1'b0, 1'b1);
		check_flags();
	endtask

	task automatic run_case(input logic ft, input logic sy, input logic inN,
			input logic outN);
		int lim;
		@(posedge clk);
		master_reset_n     <= 1'b0;
		fall_through_mode  <= ft;
		flag_timing_select <= sy;
		inNarrow           <= inN;
		outNarrow          <= outN;
		fullOffset         <= CWT'(1 + $urandom() % 5);
		emptyOffset        <= CWT'(1 + $urandom() % 5);
		repeat (4) @(posedge clk);
		master_reset_n <= 1'b1;
		occ = 0;
		expQ.delete();
		@(posedge clk);
		check_flags();
		lim = (inN && outN) ? 2 * D0 : D0;
		lim = ft ? lim + 1 : lim;
		repeat (lim) step(0);
		step(2);
		repeat (lim) step(1);
		step(3);
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		sys_rst = 1'b1;
		master_reset_n = 1'b1;
		partialResetN = 1'b1;
		fall_through_mode = 1'b0;
		flag_timing_select = 1'b0;
		inNarrow = 1'b0;
		outNarrow = 1'b0;
		fullOffset = CWT'(2);
		emptyOffset = CWT'(2);
		lastOut = 18'h00000;
		cnt = 8'h01;
		occ = 0;
		numErrors = 0;
		checksDone = 0;
		void'($urandom(17));
		repeat (20) @(posedge clk);
		check_flags();
		sys_rst <= 1'b0;
		run_case(1'b0, 1'b0, 1'b0, 1'b0);
		run_case(1'b1, 1'b1, 1'b0, 1'b0);
		run_case(1'b0, 1'b1, 1'b1, 1'b1);
		run_case(1'b1, 1'b0, 1'b1, 1'b0);
		// partial reset in mid-run: counts restart, config kept
		repeat (3) step(0);
		@(posedge clk);
		partialResetN <= 1'b0;
		repeat (4) @(posedge clk);
		partialResetN <= 1'b1;
		occ = 0;
		expQ.delete();
		@(posedge clk);
		check_flags();
		repeat (2) step(0);
		repeat (2) step(1);
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge clk);
		numErrors++;
		finish_test();
	end
endmodule

// file: testbench/fifo_peer_model.sv
`timescale 1ns/1ps

module fifo_peer_model #(
	parameter int AW = 5
) (
	input  wire logic          clk,
	input  wire logic          fall_through_mode,
	input  wire logic          full_flag_n,
	input  wire logic          empty_flag_n,
	input  wire logic [AW-1:0] arrayWriteAddr,
	input  wire logic          arrayWriteStrobe,
	input  wire logic [AW-1:0] arrayReadAddr,
	output logic               writeClk,
	output logic               writeEnableN,
	output logic               readClk,
	output logic               readEnableN,
	output logic      [17:0]   arrayData
);
	// ----------------------------------------
	// storage array and writer/reader pins
	// ----------------------------------------
	logic [17:0] mem [0:(2**AW)-1];
	logic [17:0] word;
	wire         noRoom = fall_through_mode ? full_flag_n : !full_flag_n;
	wire         noData = fall_through_mode ? empty_flag_n : !empty_flag_n;

	initial begin
		writeClk = 1'b0;
		writeEnableN = 1'b1;
		readClk = 1'b0;
		readEnableN = 1'b1;
		word = 18'h00000;
	end

	assign arrayData = mem[arrayReadAddr];

	always @(posedge clk) begin
		if (arrayWriteStrobe) begin
			mem[arrayWriteAddr] <= word;
		end
	end

	// obey low lets a scenario push past the flags on purpose
	task automatic pulse_write(input logic want, input logic obey,
			input logic [17:0] d);
		@(posedge clk);
		writeClk     <= 1'b1;
		writeEnableN <= !(want && !(obey && noRoom));
		word         <= d;
		@(posedge clk);
		writeClk     <= 1'b0;
		writeEnableN <= 1'b1;
		word         <= ~d;
	endtask

	task automatic pulse_read(input logic want, input logic obey);
		@(posedge clk);
		readClk     <= 1'b1;
		readEnableN <= !(want && !(obey && noData));
		@(posedge clk);
		readClk     <= 1'b0;
		readEnableN <= 1'b1;
	endtask
endmodule
